// [capture_exposure_gain_properties.sv]
`default_nettype none
module capture_exposure_gain_checker (
	// Clock, reset and register port
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic [15:0] reg_addr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic        reg_rd_valid,
	// Frame timing and applied settings
	input wire logic        frame_start,
	input wire logic        format_change,
	input wire logic [15:0] hconv_coarse_cur,
	input wire logic [15:0] hconv_fine_cur,
	input wire logic [6:0]  sensor_fine_gain,
	input wire logic [19:0] blklvl_dgain,
	input wire logic [19:0] proc_dgain,
	input wire logic [17:0] proc_real_gain
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	chk_rd_answer: assert property (reg_rd |=> reg_rd_valid)
		else $error("read not answered");
	chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without read");
	chk_coarse_read: assert property (reg_rd && reg_addr == 16'h350E
		|=> reg_rdata == $past(hconv_coarse_cur[15:8])) else $error("coarse readback wrong");
	chk_fine_read: assert property (reg_rd && reg_addr == 16'h3511
		|=> reg_rdata == $past(hconv_fine_cur[7:0])) else $error("fine readback wrong");
	chk_status_bits: assert property (reg_rd && reg_addr == 16'h3505
		|=> reg_rdata[7:1] == 7'h00) else $error("status unused bits set");
	chk_coarse_hold: assert property ($changed(hconv_coarse_cur) && !$past(rst)
		|-> $past(frame_start) || $past(format_change)) else $error("coarse moved off step");
	chk_fine_hold: assert property ($changed(hconv_fine_cur) && !$past(rst)
		|-> $past(frame_start) || $past(format_change)) else $error("fine moved off step");
	chk_dgain_split: assert property (blklvl_dgain == exposure_gain_pkg::DGAIN_UNITY
		|| proc_dgain == exposure_gain_pkg::DGAIN_UNITY) else $error("dgain applied twice");
	chk_rgain_frac: assert property (proc_real_gain[5:0] == 6'h00)
		else $error("pipeline gain fraction bits set");
	chk_fine_gain_lsb: assert property (sensor_fine_gain[2:0] == 3'h0)
		else $error("sensor fine gain low bits set");
	cover property (frame_start ##1 $changed(hconv_coarse_cur));
	cover property (format_change ##1 $changed(hconv_fine_cur));
	cover property (reg_rd_valid);
endmodule : capture_exposure_gain_checker
bind capture_exposure_gain_regs capture_exposure_gain_checker chk_i (.clk_sys, .rst, .reg_addr,
	.reg_rd, .reg_rdata, .reg_rd_valid, .frame_start, .format_change, .hconv_coarse_cur,
	.hconv_fine_cur, .sensor_fine_gain, .blklvl_dgain, .proc_dgain, .proc_real_gain);
`default_nettype wire

// [capture_exposure_gain_regs.sv]
`default_nettype none

module capture_exposure_gain_regs (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Register port
	input  wire logic [15:0] reg_addr,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	output logic             reg_rd_valid,
	// Frame timing
	input  wire logic        frame_start,
	input  wire logic        format_change,
	// Applied settings
	output logic      [15:0] hconv_coarse_cur,
	output logic      [15:0] hconv_fine_cur,
	output logic      [3:0]  sensor_coarse_gain,
	output logic      [6:0]  sensor_fine_gain,
	output logic      [19:0] blklvl_dgain,
	output logic      [19:0] proc_dgain,
	output logic      [17:0] proc_real_gain,
	output logic      [15:0] spix_coarse_cur
);

	typedef struct packed {
		logic [15:0]                coarse_w;
		logic [7:0]                 dly;
		logic [7:0]                 gctl;
		logic [15:0]                fine_w;
		logic [7:0]                 rg_int;
		logic [3:0]                 rg_frac;
		logic [19:0]                dg_w;
		logic [7:0]                 gmap;
		exposure_gain_pkg::item_t   coarse;
		exposure_gain_pkg::item_t   fine;
		exposure_gain_pkg::item_t   again;
		exposure_gain_pkg::item_t   dgain;
		logic [7:0]                 blc_again;
		logic [3:0]                 snr_coarse;
		logic [6:0]                 snr_fine;
		logic [19:0]                blc_dg;
		logic [19:0]                proc_dg;
		logic [17:0]                proc_rg;
		logic                       init_done;
		logic [15:0]                s_coarse_w;
		logic [7:0]                 s_dly;
		exposure_gain_pkg::item_t   s_coarse;
		logic [7:0]                 rdata;
		logic                       rvalid;
	} state_t;

	state_t state_reg;
	state_t state_next;

	// ----------------------------------------------------------------
	// Staging helpers
	// ----------------------------------------------------------------
	// True when the in-use value of an item changes on this frame step.
	function automatic logic item_upd(input exposure_gain_pkg::item_t it,
		input logic go, input logic dly, input logic force_now);
		item_upd = go && (it.wait_frame || (it.pend && (!dly || force_now)));
	endfunction : item_upd

	// A pending value goes live now, or into the hold stage for one frame.
	function automatic exposure_gain_pkg::item_t item_step(
		input exposure_gain_pkg::item_t it, input logic [19:0] wval,
		input logic go, input logic dly, input logic force_now);
		exposure_gain_pkg::item_t r;
		r = it;
		if (go) begin
			if (it.wait_frame) begin
				r.cur        = it.hold;
				r.wait_frame = 1'b0;
			end
			if (it.pend) begin
				if (dly && !force_now) begin
					r.hold       = wval;
					r.wait_frame = 1'b1;
				end else begin
					r.cur        = wval;
					r.wait_frame = 1'b0;
				end
				r.pend = 1'b0;
			end
		end
		item_step = r;
	endfunction : item_step

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic        force_now;
		logic        go;
		logic        gain_go;
		logic        expo_upd;
		logic        s_go;
		logic        s_force;
		logic [19:0] again_w;
		logic [7:0]  rd;
		force_now  = 1'b0;
		go         = 1'b0;
		gain_go    = 1'b0;
		expo_upd   = 1'b0;
		s_go       = 1'b0;
		s_force    = 1'b0;
		again_w    = 20'h00000;
		rd         = 8'h00;
		state_next = state_reg;

		// First frame after reset, or a format change, bypasses the delays.
		force_now = (!state_reg.init_done && state_reg.gctl[exposure_gain_pkg::GC_INIT_UPDATE])
			|| (format_change && state_reg.dly[exposure_gain_pkg::DLY_FMT_UPDATE]);
		go        = frame_start || (format_change
			&& state_reg.dly[exposure_gain_pkg::DLY_FMT_UPDATE]);
		if (frame_start) begin
			state_next.init_done = 1'b1;
		end

		expo_upd = item_upd(state_reg.coarse, go,
			state_reg.dly[exposure_gain_pkg::DLY_COARSE], force_now)
			|| item_upd(state_reg.fine, go,
			state_reg.dly[exposure_gain_pkg::DLY_FINE], force_now);
		// A tied gain waits for the exposure change to go live with it.
		gain_go  = go && (!state_reg.gctl[exposure_gain_pkg::GC_TIE_EXPO]
			|| expo_upd || force_now);

		state_next.coarse = item_step(state_reg.coarse, {4'h0, state_reg.coarse_w}, go,
			state_reg.dly[exposure_gain_pkg::DLY_COARSE], force_now);
		state_next.fine   = item_step(state_reg.fine, {4'h0, state_reg.fine_w}, go,
			state_reg.dly[exposure_gain_pkg::DLY_FINE], force_now);
		again_w           = {12'h000, state_reg.rg_int[3:0], state_reg.rg_frac};
		state_next.again  = item_step(state_reg.again, again_w, gain_go,
			state_reg.dly[exposure_gain_pkg::DLY_AGAIN], force_now);
		state_next.dgain  = item_step(state_reg.dgain, state_reg.dg_w, gain_go,
			state_reg.dly[exposure_gain_pkg::DLY_DGAIN], force_now);

		s_force = (!state_reg.init_done && state_reg.gctl[exposure_gain_pkg::GC_INIT_UPDATE])
			|| (format_change && state_reg.s_dly[exposure_gain_pkg::DLY_FMT_UPDATE]);
		s_go    = frame_start || (format_change
			&& state_reg.s_dly[exposure_gain_pkg::DLY_FMT_UPDATE]);
		state_next.s_coarse = item_step(state_reg.s_coarse, {4'h0, state_reg.s_coarse_w}, s_go,
			state_reg.s_dly[exposure_gain_pkg::DLY_COARSE], s_force);

		// Black level gain follows at once, or lags the sensor by one frame.
		if (state_reg.dly[exposure_gain_pkg::DLY_BLC_GAIN]) begin
			state_next.blc_again = state_next.again.cur[7:0];
		end else if (gain_go) begin
			state_next.blc_again = state_reg.again.cur[7:0];
		end

		// Derived gains are recomputed from the values in use; sensor gains come from the gain map unless GC_CALC_SENSOR is set.
		if (state_reg.gctl[exposure_gain_pkg::GC_CALC_SENSOR]) begin
			state_next.snr_coarse = state_next.again.cur[7:4];
			state_next.snr_fine   = {state_next.again.cur[3:0], 3'h0};
		end else begin
			state_next.snr_coarse = state_reg.gmap[7:4];
			state_next.snr_fine   = {state_reg.gmap[3:0], 3'h0};
		end
		if (state_reg.gctl[exposure_gain_pkg::GC_DGAIN_PROC]) begin
			state_next.blc_dg  = exposure_gain_pkg::DGAIN_UNITY;
			state_next.proc_dg = state_next.dgain.cur;
		end else begin
			state_next.blc_dg  = state_next.dgain.cur;
			state_next.proc_dg = exposure_gain_pkg::DGAIN_UNITY;
		end
		if (state_reg.gctl[exposure_gain_pkg::GC_PROC_RGAIN]) begin
			state_next.proc_rg = {4'h0, state_next.again.cur[7:0], 6'h00};
		end else begin
			state_next.proc_rg = exposure_gain_pkg::PROC_RGAIN_UNITY;
		end

		// ------------------------------------------------------------
		// Register writes; a write in the step cycle stays pending.
		// ------------------------------------------------------------
		if (reg_wr) begin
			case (reg_addr)
				exposure_gain_pkg::HCONV_COARSE_EXP_HI: begin
					state_next.coarse_w[15:8] = reg_wdata;
					state_next.coarse.pend    = 1'b1;
				end
				exposure_gain_pkg::HCONV_COARSE_EXP_LO: begin
					state_next.coarse_w[7:0] = reg_wdata;
					state_next.coarse.pend   = 1'b1;
				end
				exposure_gain_pkg::HCONV_DELAY_CTRL: begin
					state_next.dly = reg_wdata;
				end
				exposure_gain_pkg::HCONV_GAIN_CTRL: begin
					state_next.gctl = reg_wdata;
				end
				exposure_gain_pkg::HCONV_FINE_EXP_HI: begin
					state_next.fine_w[15:8] = reg_wdata;
					state_next.fine.pend    = 1'b1;
				end
				exposure_gain_pkg::HCONV_FINE_EXP_LO: begin
					state_next.fine_w[7:0] = reg_wdata;
					state_next.fine.pend   = 1'b1;
				end
				exposure_gain_pkg::HCONV_REAL_GAIN_INT: begin
					state_next.rg_int     = reg_wdata;
					state_next.again.pend = 1'b1;
				end
				exposure_gain_pkg::HCONV_REAL_GAIN_FRAC: begin
					state_next.rg_frac    = reg_wdata[7:4];
					state_next.again.pend = 1'b1;
				end
				exposure_gain_pkg::HCONV_DGAIN_HI: begin
					state_next.dg_w[19:16] = reg_wdata[3:0];
					state_next.dgain.pend  = 1'b1;
				end
				exposure_gain_pkg::HCONV_DGAIN_MID: begin
					state_next.dg_w[15:8] = reg_wdata;
					state_next.dgain.pend = 1'b1;
				end
				exposure_gain_pkg::HCONV_DGAIN_LO: begin
					state_next.dg_w[7:6]  = reg_wdata[7:6];
					state_next.dgain.pend = 1'b1;
				end
				exposure_gain_pkg::HCONV_GAIN_MAP: begin
					state_next.gmap = reg_wdata;
				end
				exposure_gain_pkg::SPIX_COARSE_EXP_HI: begin
					state_next.s_coarse_w[15:8] = reg_wdata;
					state_next.s_coarse.pend    = 1'b1;
				end
				exposure_gain_pkg::SPIX_COARSE_EXP_LO: begin
					state_next.s_coarse_w[7:0] = reg_wdata;
					state_next.s_coarse.pend   = 1'b1;
				end
				exposure_gain_pkg::SPIX_DELAY_CTRL: begin
					state_next.s_dly = reg_wdata;
				end
				default: begin
				end
			endcase
		end

		// ------------------------------------------------------------
		// Register reads, answered on the following cycle.
		// ------------------------------------------------------------
		case (reg_addr)
			exposure_gain_pkg::HCONV_COARSE_EXP_HI:  rd = state_reg.coarse_w[15:8];
			exposure_gain_pkg::HCONV_COARSE_EXP_LO:  rd = state_reg.coarse_w[7:0];
			exposure_gain_pkg::HCONV_DELAY_CTRL:     rd = state_reg.dly;
			exposure_gain_pkg::HCONV_GAIN_CTRL:      rd = state_reg.gctl;
			exposure_gain_pkg::HCONV_UPDATE_STATUS:  rd = {7'h00, state_reg.coarse.pend
				| state_reg.coarse.wait_frame | state_reg.fine.pend | state_reg.fine.wait_frame
				| state_reg.again.pend | state_reg.again.wait_frame | state_reg.dgain.pend
				| state_reg.dgain.wait_frame};
			exposure_gain_pkg::HCONV_FINE_EXP_HI:    rd = state_reg.fine_w[15:8];
			exposure_gain_pkg::HCONV_FINE_EXP_LO:    rd = state_reg.fine_w[7:0];
			exposure_gain_pkg::HCONV_REAL_GAIN_INT:  rd = state_reg.rg_int;
			exposure_gain_pkg::HCONV_REAL_GAIN_FRAC: rd = {state_reg.rg_frac, 4'h0};
			exposure_gain_pkg::HCONV_DGAIN_HI:       rd = {4'h0, state_reg.dg_w[19:16]};
			exposure_gain_pkg::HCONV_DGAIN_MID:      rd = state_reg.dg_w[15:8];
			exposure_gain_pkg::HCONV_DGAIN_LO:       rd = {state_reg.dg_w[7:6], 6'h00};
			exposure_gain_pkg::HCONV_GAIN_MAP:       rd = state_reg.gmap;
			exposure_gain_pkg::HCONV_CUR_COARSE_HI:  rd = state_reg.coarse.cur[15:8];
			exposure_gain_pkg::HCONV_CUR_COARSE_LO:  rd = state_reg.coarse.cur[7:0];
			exposure_gain_pkg::HCONV_CUR_FINE_HI:    rd = state_reg.fine.cur[15:8];
			exposure_gain_pkg::HCONV_CUR_FINE_LO:    rd = state_reg.fine.cur[7:0];
			exposure_gain_pkg::HCONV_CUR_BLKLVL_GAIN_HI:
				rd = {4'h0, state_reg.blc_again[7:4]};
			exposure_gain_pkg::HCONV_CUR_BLKLVL_GAIN_LO:
				rd = {state_reg.blc_again[3:0], 4'h0};
			exposure_gain_pkg::HCONV_RAW_GAIN_HI:
				rd = {4'h0, state_reg.again.cur[7:4]};
			exposure_gain_pkg::HCONV_RAW_GAIN_LO:
				rd = {state_reg.again.cur[3:0], 4'h0};
			exposure_gain_pkg::HCONV_CUR_SENSOR_COARSE_GAIN:
				rd = {4'h0, state_reg.snr_coarse};
			exposure_gain_pkg::HCONV_CUR_SENSOR_FINE_GAIN:
				rd = {state_reg.snr_fine, 1'b0};
			exposure_gain_pkg::HCONV_BLKLVL_DGAIN_HI: rd = {4'h0, state_reg.blc_dg[19:16]};
			exposure_gain_pkg::HCONV_BLKLVL_DGAIN_MID: rd = state_reg.blc_dg[15:8];
			exposure_gain_pkg::HCONV_BLKLVL_DGAIN_LO: rd = {state_reg.blc_dg[7:6], 6'h00};
			exposure_gain_pkg::HCONV_PROC_DGAIN_HI:  rd = {4'h0, state_reg.proc_dg[19:16]};
			exposure_gain_pkg::HCONV_PROC_DGAIN_MID: rd = state_reg.proc_dg[15:8];
			exposure_gain_pkg::HCONV_PROC_DGAIN_LO:  rd = {state_reg.proc_dg[7:6], 6'h00};
			exposure_gain_pkg::HCONV_BLKLVL_REAL_GAIN_HI:
				rd = {4'h0, state_reg.blc_again[7:4]};
			exposure_gain_pkg::HCONV_BLKLVL_REAL_GAIN_LO:
				rd = {state_reg.blc_again[3:0], 4'h0};
			exposure_gain_pkg::HCONV_PROC_REAL_GAIN_HI:  rd = state_reg.proc_rg[17:10];
			exposure_gain_pkg::HCONV_PROC_REAL_GAIN_MID: rd = state_reg.proc_rg[9:2];
			exposure_gain_pkg::HCONV_PROC_REAL_GAIN_LO:
				rd = {state_reg.proc_rg[1:0], 6'h00};
			exposure_gain_pkg::SPIX_COARSE_EXP_HI:   rd = state_reg.s_coarse_w[15:8];
			exposure_gain_pkg::SPIX_COARSE_EXP_LO:   rd = state_reg.s_coarse_w[7:0];
			exposure_gain_pkg::SPIX_DELAY_CTRL:      rd = state_reg.s_dly;
			default:                                 rd = 8'h00;
		endcase
		if (reg_rd) begin
			state_next.rdata = rd;
		end
		state_next.rvalid = reg_rd;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg                  <= '0;
			state_reg.coarse_w         <= exposure_gain_pkg::RST_HCONV_COARSE;
			state_reg.dly              <= exposure_gain_pkg::RST_DELAY_CTRL;
			state_reg.gctl             <= exposure_gain_pkg::RST_GAIN_CTRL;
			state_reg.fine_w           <= exposure_gain_pkg::RST_HCONV_FINE;
			state_reg.rg_int           <= {4'h0, exposure_gain_pkg::RST_REAL_GAIN[7:4]};
			state_reg.dg_w             <= exposure_gain_pkg::RST_DGAIN;
			state_reg.gmap             <= exposure_gain_pkg::RST_GAIN_MAP;
			state_reg.coarse.cur       <= {4'h0, exposure_gain_pkg::RST_HCONV_COARSE};
			state_reg.fine.cur         <= {4'h0, exposure_gain_pkg::RST_HCONV_FINE};
			state_reg.again.cur        <= {12'h000, exposure_gain_pkg::RST_REAL_GAIN};
			state_reg.dgain.cur        <= exposure_gain_pkg::RST_DGAIN;
			state_reg.blc_again        <= exposure_gain_pkg::RST_REAL_GAIN;
			state_reg.blc_dg           <= exposure_gain_pkg::RST_DGAIN;
			state_reg.proc_dg          <= exposure_gain_pkg::DGAIN_UNITY;
			state_reg.proc_rg          <= exposure_gain_pkg::PROC_RGAIN_UNITY;
			state_reg.s_coarse_w       <= exposure_gain_pkg::RST_SPIX_COARSE;
			state_reg.s_dly            <= exposure_gain_pkg::RST_DELAY_CTRL;
			state_reg.s_coarse.cur     <= {4'h0, exposure_gain_pkg::RST_SPIX_COARSE};
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign reg_rdata          = state_reg.rdata;
	assign reg_rd_valid       = state_reg.rvalid;
	assign hconv_coarse_cur   = state_reg.coarse.cur[15:0];
	assign hconv_fine_cur     = state_reg.fine.cur[15:0];
	assign sensor_coarse_gain = state_reg.snr_coarse;
	assign sensor_fine_gain   = state_reg.snr_fine;
	assign blklvl_dgain       = state_reg.blc_dg;
	assign proc_dgain         = state_reg.proc_dg;
	assign proc_real_gain     = state_reg.proc_rg;
	assign spix_coarse_cur    = state_reg.s_coarse.cur[15:0];

endmodule : capture_exposure_gain_regs

`default_nettype wire

// [capture_exposure_gain_regs_tb.sv]
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
	$display("unexpected at %0t: got %h want %h", $time, g, e); end end
module capture_exposure_gain_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys = '0, rst = '1, reg_wr = '0, reg_rd = '0, frame_start = '0;
	logic        format_change = '0, reg_rd_valid;
	logic [15:0] reg_addr = '0, hconv_coarse_cur, hconv_fine_cur, spix_coarse_cur;
	logic [7:0]  reg_wdata = '0, reg_rdata;
	logic [3:0]  sensor_coarse_gain;
	logic [6:0]  sensor_fine_gain;
	logic [19:0] blklvl_dgain, proc_dgain;
	logic [17:0] proc_real_gain;
	int          n_errors = 0, checked = 0, cycles = 0, i;
	logic [31:0] seed = 32'h177E, d;
	logic [15:0] ra [15] = '{16'h3501, 16'h3502, 16'h3503, 16'h3504, 16'h3506, 16'h3507,
		16'h3508, 16'h3509, 16'h350A, 16'h350B, 16'h350C, 16'h350D, 16'h3541, 16'h3542, 16'h3543};
	logic [7:0]  rv [15] = '{8'h00, 8'h08, 8'hA8, 8'h08, 8'h20, 8'h00, 8'h01, 8'h00, 8'h01,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'hA8};
	logic [7:0]  rm [15] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hF0, 8'h0F,
		8'hFF, 8'hC0, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
	logic [7:0]  wv [15] = '{8'h12, 8'h34, 8'h00, 8'hC8, 8'h56, 8'h78, 8'h05, 8'hA0, 8'h03,
		8'h45, 8'hC0, 8'h00, 8'h9A, 8'hBC, 8'h00};
	capture_exposure_gain_regs uut (.clk_sys, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
		.reg_rdata, .reg_rd_valid, .frame_start, .format_change, .hconv_coarse_cur,
		.hconv_fine_cur, .sensor_coarse_gain, .sensor_fine_gain, .blklvl_dgain, .proc_dgain,
		.proc_real_gain, .spix_coarse_cur);
	always #2.5 clk_sys = ~clk_sys;
	function automatic logic [17:0] rg(input logic [3:0] n, input logic [3:0] f);
		return {4'h0, n, f, 6'h00};
	endfunction : rg
	function automatic logic [19:0] dg(input logic [7:0] h, input logic [7:0] m, input logic [7:0] l);
		return {h[3:0], m, l[7:6], 6'h00};
	endfunction : dg
	task automatic close_out;
		if (n_errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'h1;
		@(posedge clk_sys);
		reg_wr <= 1'h0;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk_sys);
		reg_rd <= 1'h0;
		#1;
		`CHK(reg_rd_valid, 1'h1)
		`CHK(reg_rdata & m, e)
	endtask : rd
	// Pulses a frame boundary, or a format change when fmt is set.
	task automatic step(input logic fmt);
		@(posedge clk_sys);
		frame_start <= !fmt;
		format_change <= fmt;
		@(posedge clk_sys);
		frame_start <= 1'h0;
		format_change <= 1'h0;
		#1;
	endtask : step
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			close_out;
		end
	end
	initial begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'h0;
		for (i = 0; i < 15; i++) rd(ra[i], rv[i], 8'hFF);
		rd(16'h3505, 8'h00, 8'hFE);
		rd(16'h3530, 8'h00, 8'hFF);
		wr(16'h350E, 8'h55);
		rd(16'h350E, 8'h00, 8'hFF);
		for (i = 0; i < 15; i++) begin
			d = $random(seed);
			wr(ra[i], d[7:0]);
			rd(ra[i], d[7:0] & rm[i], 8'hFF);
		end
		for (i = 0; i < 15; i++) wr(ra[i], wv[i]);
		step(1'h0);
		`CHK(hconv_coarse_cur, 16'h1234)
		`CHK(hconv_fine_cur, 16'h5678)
		`CHK(sensor_coarse_gain, 4'h5)
		`CHK(sensor_fine_gain, 7'h50)
		`CHK(blklvl_dgain, dg(8'h03, 8'h45, 8'hC0))
		`CHK(proc_real_gain, rg(4'h5, 4'hA))
		`CHK(spix_coarse_cur, 16'h9ABC)
		rd(16'h3511, 8'h78, 8'hFF);
		rd(16'h3514, 8'h05, 8'hFF);
		rd(16'h3515, 8'hA0, 8'hFE);
		rd(16'h3512, 8'h01, 8'hFF);
		rd(16'h3517, 8'hA0, 8'hFF);
		rd(16'h3518, 8'h03, 8'hFF);
		rd(16'h351A, 8'hC0, 8'hFF);
		rd(16'h3520, 8'h05, 8'hFF);
		rd(16'h3521, 8'hA0, 8'hFF);
		wr(16'h3503, 8'h02);
		wr(16'h3502, 8'h77);
		step(1'h0);
		`CHK(hconv_coarse_cur, 16'h1234)
		rd(16'h3505, 8'h01, 8'hFF);
		step(1'h0);
		`CHK(hconv_coarse_cur, 16'h1277)
		rd(16'h3505, 8'h00, 8'hFF);
		wr(16'h3503, 8'h20);
		wr(16'h3507, 8'h11);
		step(1'h1);
		`CHK(hconv_fine_cur, 16'h5611)
		wr(16'h3503, 8'h10);
		wr(16'h3508, 8'h07);
		step(1'h0);
		`CHK(sensor_coarse_gain, 4'h5)
		step(1'h0);
		`CHK(sensor_coarse_gain, 4'h7)
		rd(16'h351E, 8'h05, 8'hFF);
		rd(16'h351F, 8'hA0, 8'hFF);
		wr(16'h3504, 8'hE8);
		@(posedge clk_sys);
		#1;
		`CHK(proc_dgain, dg(8'h03, 8'h45, 8'hC0))
		`CHK(blklvl_dgain, exposure_gain_pkg::DGAIN_UNITY)
		rd(16'h351C, 8'h45, 8'hFF);
		rd(16'h351D, 8'hC0, 8'hFF);
		wr(16'h3503, 8'h00);
		wr(16'h350D, 8'h9C);
		wr(16'h3504, 8'h08);
		step(1'h0);
		`CHK(sensor_coarse_gain, 4'h9)
		`CHK(sensor_fine_gain, 7'h60)
		`CHK(proc_real_gain, exposure_gain_pkg::PROC_RGAIN_UNITY)
		wr(16'h3504, 8'h18);
		wr(16'h350B, 8'h66);
		step(1'h0);
		`CHK(blklvl_dgain, dg(8'h03, 8'h45, 8'hC0))
		wr(16'h3502, 8'h01);
		step(1'h0);
		`CHK(blklvl_dgain, dg(8'h03, 8'h66, 8'hC0))
		for (i = 0; i < 16; i++) begin
			d = $random(seed);
			wr(16'h3502, d[7:0]);
			step(1'h0);
			`CHK(hconv_coarse_cur, {8'h12, d[7:0]})
		end
		close_out;
	end
endmodule : capture_exposure_gain_regs_tb
`default_nettype wire

// [exposure_gain_pkg.sv]
`default_nettype none

package exposure_gain_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [15:0] HCONV_COARSE_EXP_HI          = 16'h3501;
	localparam logic [15:0] HCONV_COARSE_EXP_LO          = 16'h3502;
	localparam logic [15:0] HCONV_DELAY_CTRL             = 16'h3503;
	localparam logic [15:0] HCONV_GAIN_CTRL              = 16'h3504;
	localparam logic [15:0] HCONV_UPDATE_STATUS          = 16'h3505;
	localparam logic [15:0] HCONV_FINE_EXP_HI            = 16'h3506;
	localparam logic [15:0] HCONV_FINE_EXP_LO            = 16'h3507;
	localparam logic [15:0] HCONV_REAL_GAIN_INT          = 16'h3508;
	localparam logic [15:0] HCONV_REAL_GAIN_FRAC         = 16'h3509;
	localparam logic [15:0] HCONV_DGAIN_HI               = 16'h350A;
	localparam logic [15:0] HCONV_DGAIN_MID              = 16'h350B;
	localparam logic [15:0] HCONV_DGAIN_LO               = 16'h350C;
	localparam logic [15:0] HCONV_GAIN_MAP               = 16'h350D;
	localparam logic [15:0] HCONV_CUR_COARSE_HI          = 16'h350E;
	localparam logic [15:0] HCONV_CUR_COARSE_LO          = 16'h350F;
	localparam logic [15:0] HCONV_CUR_FINE_HI            = 16'h3510;
	localparam logic [15:0] HCONV_CUR_FINE_LO            = 16'h3511;
	localparam logic [15:0] HCONV_CUR_BLKLVL_GAIN_HI     = 16'h3512;
	localparam logic [15:0] HCONV_CUR_BLKLVL_GAIN_LO     = 16'h3513;
	localparam logic [15:0] HCONV_RAW_GAIN_HI            = 16'h3514;
	localparam logic [15:0] HCONV_RAW_GAIN_LO            = 16'h3515;
	localparam logic [15:0] HCONV_CUR_SENSOR_COARSE_GAIN = 16'h3516;
	localparam logic [15:0] HCONV_CUR_SENSOR_FINE_GAIN   = 16'h3517;
	localparam logic [15:0] HCONV_BLKLVL_DGAIN_HI        = 16'h3518;
	localparam logic [15:0] HCONV_BLKLVL_DGAIN_MID       = 16'h3519;
	localparam logic [15:0] HCONV_BLKLVL_DGAIN_LO        = 16'h351A;
	localparam logic [15:0] HCONV_PROC_DGAIN_HI          = 16'h351B;
	localparam logic [15:0] HCONV_PROC_DGAIN_MID         = 16'h351C;
	localparam logic [15:0] HCONV_PROC_DGAIN_LO          = 16'h351D;
	localparam logic [15:0] HCONV_BLKLVL_REAL_GAIN_HI    = 16'h351E;
	localparam logic [15:0] HCONV_BLKLVL_REAL_GAIN_LO    = 16'h351F;
	localparam logic [15:0] HCONV_PROC_REAL_GAIN_HI      = 16'h3520;
	localparam logic [15:0] HCONV_PROC_REAL_GAIN_MID     = 16'h3521;
	localparam logic [15:0] HCONV_PROC_REAL_GAIN_LO      = 16'h3522;
	localparam logic [15:0] SPIX_COARSE_EXP_HI           = 16'h3541;
	localparam logic [15:0] SPIX_COARSE_EXP_LO           = 16'h3542;
	localparam logic [15:0] SPIX_DELAY_CTRL              = 16'h3543;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_HCONV_COARSE = 16'h0008;
	localparam logic [7:0]  RST_DELAY_CTRL   = 8'hA8;
	localparam logic [7:0]  RST_GAIN_CTRL    = 8'h08;
	localparam logic [15:0] RST_HCONV_FINE   = 16'h2000;
	localparam logic [7:0]  RST_REAL_GAIN    = 8'h10;
	localparam logic [19:0] RST_DGAIN        = 20'h10000;
	localparam logic [7:0]  RST_GAIN_MAP     = 8'h00;
	localparam logic [15:0] RST_SPIX_COARSE  = 16'h0004;

	// Unity gains used when a stage is bypassed.
	localparam logic [19:0] DGAIN_UNITY      = 20'h10000;
	localparam logic [17:0] PROC_RGAIN_UNITY = 18'h00400;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int DLY_BLC_GAIN   = 0;
	localparam int DLY_COARSE     = 1;
	localparam int DLY_FINE       = 2;
	localparam int DLY_AGAIN      = 4;
	localparam int DLY_FMT_UPDATE = 5;
	localparam int DLY_DGAIN      = 6;
	localparam int GC_INIT_UPDATE = 3;
	localparam int GC_TIE_EXPO    = 4;
	localparam int GC_DGAIN_PROC  = 5;
	localparam int GC_PROC_RGAIN  = 6;
	localparam int GC_CALC_SENSOR = 7;

	// One staged setting: written value waiting, delayed copy, value in use.
	typedef struct packed {
		logic        pend;
		logic        wait_frame;
		logic [19:0] hold;
		logic [19:0] cur;
	} item_t;

endpackage : exposure_gain_pkg

`default_nettype wire
